/* File: hdl/link_event_regs.sv */
// loopback control and link event interrupt register bank
// How it works
// - a loss of prbs lock sets a sticky flag at bit 10 that stays set until the register at 16h is read.
// - bit 8 reads one in normal core power, zero in power down or sleep.
// - in mac-side loopback the line transmitter is off unless bit 6 is one.
// - bits 5-2 pick digital, analog, reverse or external loopback one-hot.
// - bit 1 loops data back in the coding sublayer after symbol mapping.
// - bit 14 sets when no link forms within the programmed training time.
// - bit 12 sets when power-on reset completes.
// - bit 11 sets when no frame is seen within the configured window.
// - enable bits 6, 4 and 3 gate the three events and reset to zero.
// - the test-control register at 16h resets to 0100h.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module link_event_regs (
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    input  wire logic [4:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        write_in,
    input  wire logic        read_in,
    output logic      [15:0] rdata_out,
    input  wire logic        core_pwr_normal_in,
    input  wire logic        prbs_lock_lost_in,
    input  wire logic        training_start_in,
    input  wire logic        link_up_in,
    input  wire logic [15:0] link_timeout_in,
    input  wire logic        por_done_in,
    input  wire logic        frame_seen_in,
    input  wire logic [15:0] frame_window_in,
    input  wire logic        mii_loopback_in,
    output logic             mdi_tx_enable_out,
    output logic             lpbk_digital_out,
    output logic             lpbk_analog_out,
    output logic             lpbk_reverse_out,
    output logic             lpbk_external_out,
    output logic             pcs_lpbk_out,
    output logic             irq_out
);

    logic [6:0]  ctl_reg;
    logic        prbs_loss_reg;
    logic        core_pwr;
    logic [7:0]  en_reg;
    logic [2:0]  status_reg;
    logic [2:0]  event_hit;
    logic [2:0]  status_clr;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic [3:0]  tick_cnt_reg;
    logic        tick;
    logic [15:0] lt_count_reg;
    logic [15:0] fw_count_reg;
    logic        link_expire;
    logic        frame_expire;
    logic        mdi_tx_reg;
    logic [3:0]  lpbk_reg;
    logic        pcs_reg;
    logic        wr_ctl;
    logic        wr_status;
    logic        rd_ctl;
    logic        rd_status;
    logic [3:0]  lpbk_sel;
    logic [2:0]  en_bits;
    lpbk_regs_pkg::link_timer_state_type lt_state_reg;

    assign wr_ctl    = write_in && (addr_in == lpbk_regs_pkg::TEST_CTL_ADDR);
    assign wr_status = write_in && (addr_in == lpbk_regs_pkg::STATUS_ADDR);
    assign rd_ctl    = read_in && (addr_in == lpbk_regs_pkg::TEST_CTL_ADDR);
    assign rd_status = read_in && (addr_in == lpbk_regs_pkg::STATUS_ADDR);
    assign lpbk_sel  = ctl_reg[lpbk_regs_pkg::LPBK_MSB:lpbk_regs_pkg::LPBK_LSB];

    // power state comes from the always-on domain, so it is resynchronised
    sync_2ff #(
        .WIDTH     (1),
        .RESET_VAL (1'b1)
    ) u_pwr_sync (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .async_in (core_pwr_normal_in),
        .sync_out (core_pwr)
    );

    // writable control bits; bit 7 and above are read-only
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
            ctl_reg <= lpbk_regs_pkg::TEST_CTL_RESET[6:0];
        else if (wr_ctl)
            ctl_reg <= wdata_in[6:0];
    end

    // sticky lock-loss flag, cleared by reading; a new loss wins
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
            prbs_loss_reg <= 1'b0;
        else if (prbs_lock_lost_in)
            prbs_loss_reg <= 1'b1;
        else if (rd_ctl)
            prbs_loss_reg <= 1'b0;
    end

    // only exact one-hot codes enable a path; mixed codes select none
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            lpbk_reg <= 4'h0;
            pcs_reg  <= 1'b0;
        end
        else
        begin
            lpbk_reg[0] <= (lpbk_sel == lpbk_regs_pkg::LPBK_DIGITAL);
            lpbk_reg[1] <= (lpbk_sel == lpbk_regs_pkg::LPBK_ANALOG);
            lpbk_reg[2] <= (lpbk_sel == lpbk_regs_pkg::LPBK_REVERSE);
            lpbk_reg[3] <= (lpbk_sel == lpbk_regs_pkg::LPBK_EXTERNAL);
            pcs_reg     <= ctl_reg[lpbk_regs_pkg::PCS_LPBK_BIT];
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
            mdi_tx_reg <= 1'b1;
        else
            mdi_tx_reg <= !mii_loopback_in
                          || ctl_reg[lpbk_regs_pkg::TX_MII_BIT];
    end

    // shared microsecond tick for both windows
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
            tick_cnt_reg <= 4'h0;
        else if (tick)
            tick_cnt_reg <= 4'h0;
        else
            tick_cnt_reg <= tick_cnt_reg + 4'h1;
    end
    assign tick = (tick_cnt_reg == lpbk_regs_pkg::TICK_LAST);

    // link training timer
    assign link_expire = (lt_state_reg == lpbk_regs_pkg::LT_WAIT)
                         && !link_up_in && !training_start_in
                         && (lt_count_reg == link_timeout_in);

    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            lt_state_reg <= lpbk_regs_pkg::LT_IDLE;
            lt_count_reg <= 16'h0000;
        end
        else if (training_start_in)
        begin
            lt_state_reg <= lpbk_regs_pkg::LT_WAIT;
            lt_count_reg <= 16'h0000;
        end
        else
        begin
            case (lt_state_reg)
                lpbk_regs_pkg::LT_WAIT:
                begin
                    if (link_up_in)
                        lt_state_reg <= lpbk_regs_pkg::LT_IDLE;
                    else if (link_expire)
                        lt_state_reg <= lpbk_regs_pkg::LT_EXPIRED;
                    else if (tick)
                        lt_count_reg <= lt_count_reg + 16'h0001;
                end
                lpbk_regs_pkg::LT_EXPIRED:
                begin
                    if (link_up_in)
                        lt_state_reg <= lpbk_regs_pkg::LT_IDLE;
                end
                default:
                    lt_state_reg <= lpbk_regs_pkg::LT_IDLE;
            endcase
        end
    end

    // frame watchdog; a zero window turns it off
    assign frame_expire = (frame_window_in != 16'h0000) && !frame_seen_in
                          && (fw_count_reg == frame_window_in);

    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
            fw_count_reg <= 16'h0000;
        else if (frame_seen_in || frame_expire)
            fw_count_reg <= 16'h0000;
        else if (tick && (frame_window_in != 16'h0000))
            fw_count_reg <= fw_count_reg + 16'h0001;
    end

    // event flags: 2 no link, 1 por done, 0 no frame
    assign event_hit = {link_expire, por_done_in, frame_expire};
    assign en_bits   = {en_reg[lpbk_regs_pkg::NO_LINK_EN_BIT],
                        en_reg[lpbk_regs_pkg::POR_EN_BIT],
                        en_reg[lpbk_regs_pkg::NO_FRAME_EN_BIT]};

    genvar i;
    generate
        for (i = 0; i < 3; i++)
        begin : g_flag
            // read clears all, a one at 11, 12 or 14 clears one; event wins
            assign status_clr[i] = rd_status || (wr_status
                && wdata_in[lpbk_regs_pkg::NO_FRAME_BIT + i + i / 2]);
            always_ff @(posedge clock_in)
            begin
                if (!rstn_in)
                    status_reg[i] <= 1'b0;
                else if (event_hit[i])
                    status_reg[i] <= 1'b1;
                else if (status_clr[i])
                    status_reg[i] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
            en_reg <= lpbk_regs_pkg::EN_RESET;
        else if (wr_status)
            en_reg <= wdata_in[7:0];
    end

    assign irq_out = |(status_reg & en_bits);

    // read data stand for one cycle only, zero otherwise
    always_comb
    begin
        rdata_next = 16'h0000;
        if (rd_ctl)
        begin
            rdata_next[6:0] = ctl_reg;
            rdata_next[lpbk_regs_pkg::CORE_PWR_BIT]  = core_pwr;
            rdata_next[lpbk_regs_pkg::PRBS_LOSS_BIT] = prbs_loss_reg;
        end
        else if (rd_status)
        begin
            rdata_next[7:0] = en_reg;
            rdata_next[lpbk_regs_pkg::NO_LINK_BIT]  = status_reg[2];
            rdata_next[lpbk_regs_pkg::POR_DONE_BIT] = status_reg[1];
            rdata_next[lpbk_regs_pkg::NO_FRAME_BIT] = status_reg[0];
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
            rdata_reg <= 16'h0000;
        else
            rdata_reg <= rdata_next;
    end

    assign rdata_out         = rdata_reg;
    assign mdi_tx_enable_out = mdi_tx_reg;
    assign lpbk_digital_out  = lpbk_reg[0];
    assign lpbk_analog_out   = lpbk_reg[1];
    assign lpbk_reverse_out  = lpbk_reg[2];
    assign lpbk_external_out = lpbk_reg[3];
    assign pcs_lpbk_out      = pcs_reg;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_ctl_read;
        rd_ctl ##1 1'b1;
    endsequence

    sequence s_training_lapse;
        (lt_state_reg == lpbk_regs_pkg::LT_WAIT) && !link_up_in
        && !training_start_in && (lt_count_reg == link_timeout_in);
    endsequence

    a_prbs_loss_read: assert property (
        prbs_lock_lost_in ##1 !rd_ctl ##1 s_ctl_read |-> rdata_out[10])
        else $error("prbs loss not reported on read");

    a_prbs_loss_hold: assert property (
        prbs_loss_reg && !rd_ctl |=> prbs_loss_reg)
        else $error("prbs loss flag dropped without a read");

    a_core_pwr_follow: assert property (
        !core_pwr_normal_in [*3] ##1 rd_ctl |=> !rdata_out[8])
        else $error("core power bit not low in sleep");

    a_mdi_suppress: assert property (
        mii_loopback_in && !ctl_reg[6] |=> !mdi_tx_enable_out)
        else $error("line transmit not suppressed in mii loopback");

    a_lpbk_onehot: assert property (
        wr_ctl && (wdata_in[5:2] == 4'h4) |-> ##2 lpbk_reverse_out
        && !lpbk_digital_out && !lpbk_analog_out && !lpbk_external_out)
        else $error("reverse loopback not selected alone");

    a_pcs_lpbk: assert property (
        wr_ctl |-> ##2 (pcs_lpbk_out == $past(wdata_in[1], 2)))
        else $error("pcs loopback does not follow bit 1");

    a_link_timeout: assert property (
        s_training_lapse |=> status_reg[2]
        && (lt_state_reg == lpbk_regs_pkg::LT_EXPIRED))
        else $error("link timeout not flagged");

    a_link_up_quiet: assert property (
        link_up_in && !status_reg[2] |=> !status_reg[2])
        else $error("link timeout flagged while link up");

    a_por_done: assert property (
        por_done_in ##1 !status_clr[1] ##1 rd_status |=> rdata_out[12])
        else $error("por done not reported");

    a_no_frame: assert property (
        frame_seen_in |=> !status_reg[0] || $past(status_reg[0]))
        else $error("no-frame flagged right after a frame");

    a_enable_reset: assert property (
        $rose(rstn_in) |-> (en_reg == 8'h25) && !irq_out)
        else $error("enable register reset value wrong");

    a_irq_gate: assert property (
        rd_status && !(|event_hit) ##1 !(|event_hit) |-> !irq_out [*2])
        else $error("irq stayed high after read clear");

    a_ctl_reset: assert property (
        $rose(rstn_in) |-> (ctl_reg == 7'h00) && core_pwr)
        else $error("test control reset value wrong");

endmodule // link_event_regs
`default_nettype wire

/* File: hdl/lpbk_regs_pkg.sv */
// constants shared by the loopback and link event register bank
package lpbk_regs_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [4:0] TEST_CTL_ADDR = 5'h16;
    localparam logic [4:0] STATUS_ADDR   = 5'h18;

    // loopback_test_control fields
    localparam int PRBS_LOSS_BIT = 10;
    localparam int CORE_PWR_BIT  = 8;
    localparam int TX_MII_BIT    = 6;
    localparam int LPBK_LSB      = 2;
    localparam int LPBK_MSB      = 5;
    localparam int PCS_LPBK_BIT  = 1;
    localparam int CTL_W         = 7;
    localparam logic [15:0] TEST_CTL_RESET = 16'h0100;

    // loopback select codes
    localparam logic [3:0] LPBK_DIGITAL  = 4'h1;
    localparam logic [3:0] LPBK_ANALOG   = 4'h2;
    localparam logic [3:0] LPBK_REVERSE  = 4'h4;
    localparam logic [3:0] LPBK_EXTERNAL = 4'h8;

    // link_event_interrupt_status fields
    localparam int NO_LINK_BIT     = 14;
    localparam int POR_DONE_BIT    = 12;
    localparam int NO_FRAME_BIT    = 11;
    localparam int NO_LINK_EN_BIT  = 6;
    localparam int POR_EN_BIT      = 4;
    localparam int NO_FRAME_EN_BIT = 3;
    localparam logic [7:0] EN_RESET = 8'h25;

    // timer tick for the link and frame windows
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int TICK_NS         = 1000;
    localparam int TICK_CYCLES     = TICK_NS / CLOCK_PERIOD_NS;
    localparam logic [3:0] TICK_LAST = 4'(TICK_CYCLES - 1);

    typedef enum logic [1:0] {
        LT_IDLE    = 2'b00,
        LT_WAIT    = 2'b01,
        LT_EXPIRED = 2'b11
    } link_timer_state_type;

endpackage

/* File: hdl/sync_2ff.sv */
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
    parameter int         WIDTH     = 1,
    parameter logic [0:0] RESET_VAL = 1'b0
) (
    input  wire logic             clock_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge clock_in)
            begin
                if (!rstn_in)
                begin
                    meta_reg <= RESET_VAL;
                    sync_reg <= RESET_VAL;
                end
                else
                begin
                    meta_reg <= async_in[i];
                    sync_reg <= meta_reg;
                end
            end
            assign sync_out[i] = sync_reg;
        end
    endgenerate

endmodule // sync_2ff
`default_nettype wire

/* File: verif/link_event_regs_tb.sv */
// self-checking testbench for the loopback and link event register bank
`timescale 1ns/1ps
`default_nettype none
module link_event_regs_tb;
    localparam logic [4:0] CTL = lpbk_regs_pkg::TEST_CTL_ADDR;
    localparam logic [4:0] STS = lpbk_regs_pkg::STATUS_ADDR;
    localparam logic [3:0] EV_PRBS  = 4'h1;
    localparam logic [3:0] EV_POR   = 4'h2;
    localparam logic [3:0] EV_FRAME = 4'h4;
    localparam logic [3:0] EV_TRAIN = 4'h8;

    logic        clock_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [4:0]  addr_in = 5'h00;
    logic [15:0] wdata_in = 16'h0000;
    logic        write_in = 1'b0;
    logic        read_in = 1'b0;
    logic [15:0] rdata_out;
    logic        core_pwr_normal_in = 1'b1;
    logic        prbs_lock_lost_in = 1'b0;
    logic        training_start_in = 1'b0;
    logic        link_up_in = 1'b0;
    logic [15:0] link_timeout_in = 16'h0002;
    logic        por_done_in = 1'b0;
    logic        frame_seen_in = 1'b0;
    logic [15:0] frame_window_in = 16'h0000;
    logic        mii_loopback_in = 1'b0;
    logic        mdi_tx_enable_out;
    logic        lpbk_digital_out;
    logic        lpbk_analog_out;
    logic        lpbk_reverse_out;
    logic        lpbk_external_out;
    logic        pcs_lpbk_out;
    logic        irq_out;
    logic [15:0] exp_q[$];
    logic        pend = 1'b0;
    int          fail_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [3:0]  code;

    link_event_regs dut (
        .clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
        .rdata_out(rdata_out), .core_pwr_normal_in(core_pwr_normal_in),
        .prbs_lock_lost_in(prbs_lock_lost_in),
        .training_start_in(training_start_in), .link_up_in(link_up_in),
        .link_timeout_in(link_timeout_in), .por_done_in(por_done_in),
        .frame_seen_in(frame_seen_in), .frame_window_in(frame_window_in),
        .mii_loopback_in(mii_loopback_in),
        .mdi_tx_enable_out(mdi_tx_enable_out),
        .lpbk_digital_out(lpbk_digital_out),
        .lpbk_analog_out(lpbk_analog_out),
        .lpbk_reverse_out(lpbk_reverse_out),
        .lpbk_external_out(lpbk_external_out),
        .pcs_lpbk_out(pcs_lpbk_out), .irq_out(irq_out)
    );

    always #50 clock_in = ~clock_in;

    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", what, e, g);
            fail_count++;
        end
    endtask

    task automatic results();
        if (fail_count == 0 && tests_run > 0 && exp_q.size() == 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= d;
        write_in <= 1'b1;
        @(posedge clock_in);
        write_in <= 1'b0;
    endtask

    // expected word is queued here, compared by the monitor below
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clock_in);
        addr_in <= a;
        read_in <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock_in);
        read_in <= 1'b0;
    endtask

    // {mdi, digital, analog, reverse, external, pcs, irq}
    task automatic outs(input logic [6:0] e);
        @(negedge clock_in);
        chk("outputs", {9'h000, e}, {9'h000, mdi_tx_enable_out,
            lpbk_digital_out, lpbk_analog_out, lpbk_reverse_out,
            lpbk_external_out, pcs_lpbk_out, irq_out});
        @(posedge clock_in);
    endtask

    task automatic irq_is(input logic e);
        @(negedge clock_in);
        chk("irq", {15'h0000, e}, {15'h0000, irq_out});
        @(posedge clock_in);
    endtask

    // one-cycle pulse on the event inputs picked by the mask
    task automatic pulse(input logic [3:0] which);
        @(posedge clock_in);
        {training_start_in, frame_seen_in, por_done_in,
         prbs_lock_lost_in} <= which;
        @(posedge clock_in);
        {training_start_in, frame_seen_in, por_done_in,
         prbs_lock_lost_in} <= 4'h0;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clock_in)
    begin
        if (pend && exp_q.size() > 0)
            chk("rdata", exp_q.pop_front(), rdata_out);
        pend <= read_in && rstn_in;
    end

    // run should need well under a thousand cycles
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            results();
        end
    end

    initial
    begin
        void'($urandom(358));
        cyc(10);
        rstn_in <= 1'b1;
        outs(7'b1000000);
        rd(CTL, 16'h0100);
        rd(STS, 16'h0025);
        for (int i = 0; i < 4; i++)
        begin
            code = 4'h1 << i;
            wr(CTL, {10'h000, code, 2'b00});
            cyc(2);
            outs({1'b1, code[0], code[1], code[2], code[3], 2'b00});
            rd(CTL, {7'h00, 1'b1, 2'b00, code, 2'b00});
        end
        wr(CTL, 16'h000c);
        cyc(2);
        outs(7'b1000000);
        wr(CTL, 16'h0002);
        cyc(2);
        outs(7'b1000010);
        wr(CTL, 16'h0000);
        mii_loopback_in <= 1'b1;
        cyc(2);
        outs(7'b0000000);
        wr(CTL, 16'h0040);
        cyc(2);
        outs(7'b1000000);
        mii_loopback_in <= 1'b0;
        wr(CTL, 16'hffff);
        rd(CTL, 16'h017f);
        wr(CTL, 16'h0000);
        core_pwr_normal_in <= 1'b0;
        cyc(4);
        rd(CTL, 16'h0000);
        core_pwr_normal_in <= 1'b1;
        cyc(4);
        pulse(EV_PRBS);
        rd(CTL, 16'h0500);
        rd(CTL, 16'h0100);
        wr(5'h17, 16'hffff);
        rd(5'h17, 16'h0000);
        rd(CTL, 16'h0100);
        wr(STS, 16'h0035);
        pulse(EV_POR);
        cyc(2);
        irq_is(1'b1);
        wr(STS, 16'h0025);
        irq_is(1'b0);
        rd(STS, 16'h1025);
        rd(STS, 16'h0025);
        pulse(EV_POR);
        rd(STS, 16'h1025);
        pulse(EV_POR);
        cyc(2);
        wr(STS, 16'h1025);
        rd(STS, 16'h0025);
        wr(STS, 16'h002d);
        frame_window_in <= 16'h0002;
        repeat (12)
        begin
            pulse(EV_FRAME);
            cyc($urandom_range(1, 6));
        end
        irq_is(1'b0);
        cyc(40);
        irq_is(1'b1);
        frame_window_in <= 16'h0000;
        cyc(5);
        rd(STS, 16'h082d);
        rd(STS, 16'h002d);
        wr(STS, 16'h0065);
        pulse(EV_TRAIN);
        cyc(50);
        irq_is(1'b1);
        link_up_in <= 1'b1;
        rd(STS, 16'h4065);
        rd(STS, 16'h0065);
        link_up_in <= 1'b0;
        pulse(EV_TRAIN);
        cyc(5);
        link_up_in <= 1'b1;
        cyc(50);
        rd(STS, 16'h0065);
        irq_is(1'b0);
        cyc(3);
        results();
    end
endmodule // link_event_regs_tb
`default_nettype wire
